// *** src/battery_temp_monitor.sv ***
// spi register file, converter control and supply monitor top
`timescale 1ns/1ps
`include "bt_cfg.svh"
module battery_temp_monitor
   import bt_pkg::*;
#(
   parameter int CONV_CYC   = `BT_CONV_US * `BT_CLK_MHZ,
   parameter int PERIOD_CYC = `BT_LBD_PERIOD_MS * 1000 * `BT_CLK_MHZ,
   parameter int WINDOW_CYC = `BT_LBD_WINDOW_US * `BT_CLK_MHZ
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       spi_sck,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   output logic            spi_miso_oe,
   output logic            interrupt_request_n,
   input  wire logic       sleep_mode,
   input  wire logic       atb_temp_sel,
   input  wire logic [7:0] adc_result,
   input  wire logic [4:0] vbat_code,
   output logic            conv_power,
   output logic [2:0]      conv_input_sel,
   output logic [1:0]      conv_ref_sel,
   output logic [7:0]      amp_gain_num,
   output logic [3:0]      amp_offset_steps,
   output logic            temp_sensor_on,
   output logic [1:0]      temp_range,
   output logic            thermal_shift_enable,
   output logic [3:0]      bandgap_trim,
   output logic [7:0]      temp_value_offset,
   output logic            low_supply_detector_power,
   output logic            rc_osc_on
);

   localparam int CCW = $clog2(CONV_CYC + 1);

   // ------------
   // elaboration checks
   // ------------
   if (CONV_CYC < 1) begin : g_bad
      $error("conversion time must be at least one cycle");
   end

   // ------------
   // decoding functions
   // ------------
   // true for either interrupt status register
   function automatic logic is_status(input reg_addr_t a);
      return (a == `BT_OFF_IRQ_STAT1) || (a == `BT_OFF_IRQ_STAT2);
   endfunction

   // gain numerator over 13; third-supply set is 3/2 of half-supply set
   function automatic logic [7:0] gain_num(input logic [1:0] g,
                                           input logic       r);
      logic [7:0] base;
      base = 8'h16 * {6'h00, g} + 8'h16;   // 22, 44, 66, 88  R1
      return r ? base + (base >> 1) : base; // R2
   endfunction

   // ------------
   // pin synchronisers
   // ------------
   logic [2:0] sck_s_r, cs_s_r, mosi_s_r;   // sync chains
   logic       sck_f_r, cs_f_r, mosi_f_r;   // agreed values
   logic       sck_f_nxt, cs_f_nxt, mosi_f_nxt;

   // a change counts once stages two and three agree
   always_comb begin
      sck_f_nxt  = (sck_s_r[1] == sck_s_r[2]) ? sck_s_r[2] : sck_f_r;
      cs_f_nxt   = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_f_r;
      mosi_f_nxt = (mosi_s_r[1] == mosi_s_r[2]) ? mosi_s_r[2] : mosi_f_r;
   end

   // chains and filtered levels
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sck_s_r  <= 3'h0;
         cs_s_r   <= 3'h7;
         mosi_s_r <= 3'h0;
         sck_f_r  <= 1'b0;
         cs_f_r   <= 1'b1;
         mosi_f_r <= 1'b0;
      end else if (ce) begin
         sck_s_r  <= {sck_s_r[1:0], spi_sck};
         cs_s_r   <= {cs_s_r[1:0], spi_cs_n};
         mosi_s_r <= {mosi_s_r[1:0], spi_mosi};
         sck_f_r  <= sck_f_nxt;
         cs_f_r   <= cs_f_nxt;
         mosi_f_r <= mosi_f_nxt;
      end
   end

   // ------------
   // spi slave: rw bit, 7 address bits, 8 data bits, bursts increment
   // ------------
   logic       sck_rise, sck_fall, cs_act;
   logic [4:0] bit_r, bit_nxt;          // bits taken in this frame
   logic [7:0] shin_r, shin_nxt;        // incoming bits
   logic       rw_r, rw_nxt;            // 1 = write
   reg_addr_t  addr_r, addr_nxt;        // current address
   reg_byte_t  shout_r, shout_nxt;      // outgoing bits
   logic       miso_r, miso_nxt;
   logic       miso_oe_r, miso_oe_nxt;
   logic       wr_fire, rd_fire;        // access strobes
   reg_addr_t  rd_addr;                 // address being read
   reg_byte_t  wr_data;                 // byte being written
   reg_byte_t  rd_data;                 // read mux output

   // frame sequencing
   always_comb begin
      sck_rise    = sck_f_nxt & ~sck_f_r;
      sck_fall    = ~sck_f_nxt & sck_f_r;
      cs_act      = ~cs_f_r;
      bit_nxt     = bit_r;
      shin_nxt    = shin_r;
      rw_nxt      = rw_r;
      addr_nxt    = addr_r;
      shout_nxt   = shout_r;
      miso_nxt    = miso_r;
      miso_oe_nxt = cs_act;
      wr_fire     = 1'b0;
      rd_fire     = 1'b0;
      rd_addr     = addr_r;
      wr_data     = {shin_r[6:0], mosi_f_nxt};
      if (!cs_act) begin
         // idle between frames
         bit_nxt  = 5'h00;
         miso_nxt = 1'b0;
      end else if (sck_rise) begin
         // sample on rising clock
         shin_nxt = {shin_r[6:0], mosi_f_nxt};
         bit_nxt  = bit_r + 5'h01;
         if (bit_r == 5'h00) begin
            rw_nxt = mosi_f_nxt;
         end
         if (bit_r == 5'h07) begin
            addr_nxt = {shin_r[5:0], mosi_f_nxt};
            rd_addr  = addr_nxt;
            rd_fire  = ~rw_r;
         end
         if (bit_r == 5'h0f) begin
            wr_fire  = rw_r;
            bit_nxt  = 5'h08;
            addr_nxt = addr_r + 7'h01;
            rd_addr  = addr_nxt;
            rd_fire  = ~rw_r;
         end
      end else if (sck_fall && bit_r >= 5'h08) begin
         // shift out on falling clock
         miso_nxt  = shout_r[7];
         shout_nxt = {shout_r[6:0], 1'b0};
      end
      if (rd_fire) begin
         shout_nxt = rd_data;
      end
   end

   // frame registers
   always_ff @(posedge core_clk) begin
      if (srst) begin
         bit_r     <= 5'h00;
         shin_r    <= 8'h00;
         rw_r      <= 1'b0;
         addr_r    <= 7'h00;
         shout_r   <= 8'h00;
         miso_r    <= 1'b0;
         miso_oe_r <= 1'b0;
      end else if (ce) begin
         bit_r     <= bit_nxt;
         shin_r    <= shin_nxt;
         rw_r      <= rw_nxt;
         addr_r    <= addr_nxt;
         shout_r   <= shout_nxt;
         miso_r    <= miso_nxt;
         miso_oe_r <= miso_oe_nxt;
      end
   end

   // ------------
   // register file
   // ------------
   reg_byte_t  ts_ctrl_r, ts_ctrl_nxt;      // temp_sensor_control
   reg_byte_t  tv_offs_r, tv_offs_nxt;      // temp_value_offset
   logic [4:0] thr_r, thr_nxt;              // battery_threshold_reg
   logic [6:0] adc_cfg_r, adc_cfg_nxt;      // converter cfg, no start
   logic [3:0] amp_offs_r, amp_offs_nxt;    // coarse amp offset
   reg_byte_t  irq_en2_r, irq_en2_nxt;      // interrupt enables
   reg_byte_t  op_ctrl1_r, op_ctrl1_nxt;    // operating mode control
   logic       flag_r, flag_nxt;            // low supply status
   logic       busy_r, busy_nxt;            // conversion running
   logic [CCW-1:0] ccnt_r, ccnt_nxt;        // conversion cycles
   reg_byte_t  adc_val_r, adc_val_nxt;      // last conversion
   logic       lbd_en;
   logic [4:0] level;
   logic       low_event;
   logic       smp_power;

   assign lbd_en = op_ctrl1_r[`BT_LBD_EN_BIT];

   // read mux
   always_comb begin
      case (rd_addr)
         `BT_OFF_IRQ_STAT2: rd_data = 8'(flag_r) << `BT_LBD_FLAG_BIT;
         `BT_OFF_IRQ_EN2:   rd_data = irq_en2_r;
         `BT_OFF_OP_CTRL1:  rd_data = op_ctrl1_r;
         `BT_OFF_ADC_CFG:   rd_data = {busy_r, adc_cfg_r}; // R19
         `BT_OFF_AMP_OFFS:  rd_data = {4'h0, amp_offs_r};
         `BT_OFF_ADC_VALUE: rd_data = adc_val_r;
         `BT_OFF_TS_CTRL:   rd_data = ts_ctrl_r;
         `BT_OFF_TV_OFFS:   rd_data = tv_offs_r;
         `BT_OFF_LBD_THR:   rd_data = {3'h0, thr_r}; // R12
         `BT_OFF_LBD_LEVEL: rd_data = lbd_en ? {3'h0, level} : 8'h00; // R14
         default:           rd_data = 8'h00;
      endcase
   end

   // register writes, status clear, conversion timer
   always_comb begin
      ts_ctrl_nxt  = ts_ctrl_r;
      tv_offs_nxt  = tv_offs_r;
      thr_nxt      = thr_r;
      adc_cfg_nxt  = adc_cfg_r;
      amp_offs_nxt = amp_offs_r;
      irq_en2_nxt  = irq_en2_r;
      op_ctrl1_nxt = op_ctrl1_r;
      busy_nxt     = busy_r;
      ccnt_nxt     = ccnt_r;
      adc_val_nxt  = adc_val_r;
      if (wr_fire) begin
         case (addr_r)
            `BT_OFF_TS_CTRL:  ts_ctrl_nxt  = wr_data;
            `BT_OFF_TV_OFFS:  tv_offs_nxt  = wr_data;
            `BT_OFF_LBD_THR:  thr_nxt      = wr_data[4:0]; // R12
            `BT_OFF_AMP_OFFS: amp_offs_nxt = wr_data[3:0];
            `BT_OFF_IRQ_EN2:  irq_en2_nxt  = wr_data;
            `BT_OFF_OP_CTRL1: op_ctrl1_nxt = wr_data;
            `BT_OFF_ADC_CFG: begin
               adc_cfg_nxt = wr_data[6:0];
               // start ignored while a conversion runs
               if (wr_data[`BT_ADC_START_BIT] && !busy_r) begin
                  busy_nxt = 1'b1;
                  ccnt_nxt = '0;
               end
            end
            default: begin
               // unmapped and read-only addresses ignore writes
            end
         endcase
      end
      if (busy_r) begin
         ccnt_nxt = ccnt_r + 1'b1;
         if (ccnt_r == CCW'(CONV_CYC - 1)) begin
            busy_nxt    = 1'b0; // R19
            adc_val_nxt = adc_result; // R4
         end
      end
      // an event in the clearing cycle wins
      flag_nxt = low_event
               | (flag_r & ~(rd_fire & is_status(rd_addr))); // R20
   end

   // register file state
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ts_ctrl_r  <= `BT_RST_TS_CTRL; // R9
         tv_offs_r  <= `BT_RST_TV_OFFS;
         thr_r      <= `BT_RST_LBD_THR; // R12
         adc_cfg_r  <= `BT_RST_ADC_CFG;
         amp_offs_r <= `BT_RST_AMP_OFFS;
         irq_en2_r  <= `BT_RST_IRQ_EN2;
         op_ctrl1_r <= `BT_RST_OP_CTRL1;
         flag_r     <= 1'b0;
         busy_r     <= 1'b0;
         ccnt_r     <= '0;
         adc_val_r  <= 8'h00;
      end else if (ce) begin
         ts_ctrl_r  <= ts_ctrl_nxt;
         tv_offs_r  <= tv_offs_nxt;
         thr_r      <= thr_nxt;
         adc_cfg_r  <= adc_cfg_nxt;
         amp_offs_r <= amp_offs_nxt;
         irq_en2_r  <= irq_en2_nxt;
         op_ctrl1_r <= op_ctrl1_nxt;
         flag_r     <= flag_nxt;
         busy_r     <= busy_nxt;
         ccnt_r     <= ccnt_nxt;
         adc_val_r  <= adc_val_nxt;
      end
   end

   // ------------
   // supply sampler
   // ------------
   supply_sampler #(
      .PERIOD_CYC (PERIOD_CYC),
      .WINDOW_CYC (WINDOW_CYC)
   ) u_sampler (
      .core_clk     (core_clk),
      .srst         (srst),
      .ce           (ce),
      .enable       (lbd_en),
      .threshold    (thr_r),
      .vbat_code    (vbat_code),
      .sensor_power (smp_power),
      .level        (level),
      .low_event    (low_event)
   );

   // ------------
   // analog control outputs, all registered
   // ------------
   logic [2:0] sel_w;
   logic [1:0] ref_w, gain_w;
   logic       irq_n_r, irq_n_nxt;
   logic [7:0] gain_r, gain_nxt;
   logic [3:0] offs_r, offs_nxt;
   logic       ts_on_r, ts_on_nxt;
   logic [3:0] trim_r, trim_nxt;
   logic       osc_r, osc_nxt;
   logic       pwr_r;

   // decode controls for the analog side
   always_comb begin
      sel_w     = adc_cfg_r[`BT_ADCSEL_LSB +: 3];
      ref_w     = adc_cfg_r[`BT_ADCREF_LSB +: 2];
      gain_w    = adc_cfg_r[`BT_GAIN_LSB +: 2];
      gain_nxt  = gain_num(gain_w, ref_w[0]); // R1
      // top bit set: +low*step, clear: -(8-low) or zero
      if (amp_offs_r[3] || amp_offs_r[2:0] != 3'h0) begin
         offs_nxt = amp_offs_r ^ 4'h8; // R3
      end else begin
         offs_nxt = 4'h0; // R3
      end
      ts_on_nxt = (sel_w == `BT_SEL_TEMP) | atb_temp_sel; // R6
      trim_nxt  = ts_ctrl_r[`BT_TS_TRIM_EN_BIT] ? ts_ctrl_r[3:0]
                                                : 4'h0; // R11
      osc_nxt   = lbd_en & sleep_mode; // R16
      irq_n_nxt = ~(flag_r & irq_en2_r[`BT_LBD_FLAG_BIT]); // R18
   end

   // output flops
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_n_r <= 1'b1;
         gain_r  <= 8'h16;
         offs_r  <= 4'h0;
         ts_on_r <= 1'b0;
         trim_r  <= 4'h0;
         osc_r   <= 1'b0;
         pwr_r   <= 1'b0;
      end else if (ce) begin
         irq_n_r <= irq_n_nxt;
         gain_r  <= gain_nxt;
         offs_r  <= offs_nxt;
         ts_on_r <= ts_on_nxt;
         trim_r  <= trim_nxt;
         osc_r   <= osc_nxt;
         pwr_r   <= smp_power; // R15
      end
   end

   assign spi_miso                  = miso_r;
   assign spi_miso_oe               = miso_oe_r;
   assign interrupt_request_n       = irq_n_r;
   assign conv_power                = busy_r;
   assign conv_input_sel            = adc_cfg_r[`BT_ADCSEL_LSB +: 3];
   assign conv_ref_sel              = adc_cfg_r[`BT_ADCREF_LSB +: 2];
   assign amp_gain_num              = gain_r;
   assign amp_offset_steps          = offs_r;
   assign temp_sensor_on            = ts_on_r;
   assign temp_range                = ts_ctrl_r[`BT_TS_RANGE_LSB +: 2]; // R8
   assign thermal_shift_enable      = ts_ctrl_r[`BT_TS_SHIFT_BIT]; // R9
   assign bandgap_trim              = trim_r;
   assign temp_value_offset         = tv_offs_r;
   assign low_supply_detector_power = pwr_r;
   assign rc_osc_on                 = osc_r;

endmodule

// *** shared/bt_cfg.svh ***
// offsets, field positions, reset values and timing counts of the monitor
//
// Behaviour
// R1: gain field picks gain per reference
// R2: gain pair cancels the reference ratio
// R3: coarse offset in 0.12 percent supply steps
// R4: differential input unipolar, offset shifts positive
// R5: host picks half or third supply reference
// R6: sensor powered when selected as input
// R7: host sequence for reading temperature
// R8: range field selects four shifted ranges
// R9: shift disabled gives absolute kelvin test mode
// R10: host scales code by step plus base
// R11: bandgap trim applied only when enabled
// R12: five bit threshold, reset 14h
// R13: detector runs only while enabled
// R14: five bit supply code, 50 mV steps
// R15: detector powered 250 us every second
// R16: detector in sleep starts rc oscillator
// R17: four consecutive low samples raise interrupt
// R18: low supply drives interrupt line low
// R19: start bit self-clears after 350 us
// R20: flag holds until status read
`ifndef BT_CFG_SVH
`define BT_CFG_SVH

// ------------
// register offsets
// ------------
`define BT_OFF_IRQ_STAT1  7'h03
`define BT_OFF_IRQ_STAT2  7'h04
`define BT_OFF_IRQ_EN2    7'h06
`define BT_OFF_OP_CTRL1   7'h07
`define BT_OFF_ADC_CFG    7'h0f
`define BT_OFF_AMP_OFFS   7'h10
`define BT_OFF_ADC_VALUE  7'h11
`define BT_OFF_TS_CTRL    7'h12
`define BT_OFF_TV_OFFS    7'h13
`define BT_OFF_LBD_THR    7'h1a
`define BT_OFF_LBD_LEVEL  7'h1b

// ------------
// reset values
// ------------
`define BT_RST_TS_CTRL    8'h20
`define BT_RST_TV_OFFS    8'h00
`define BT_RST_LBD_THR    5'h14
`define BT_RST_ADC_CFG    7'h00
`define BT_RST_AMP_OFFS   4'h0
`define BT_RST_IRQ_EN2    8'h00
`define BT_RST_OP_CTRL1   8'h00

// ------------
// field positions
// ------------
`define BT_ADC_START_BIT  7
`define BT_ADCSEL_LSB     4
`define BT_ADCREF_LSB     2
`define BT_GAIN_LSB       0
`define BT_TS_RANGE_LSB   6
`define BT_TS_SHIFT_BIT   5
`define BT_TS_TRIM_EN_BIT 4
`define BT_LBD_EN_BIT     6
`define BT_LBD_FLAG_BIT   2
`define BT_SEL_TEMP       3'h0

// ------------
// timing
// ------------
`define BT_CLK_MHZ        250
`define BT_CONV_US        350
`define BT_LBD_PERIOD_MS  1000
`define BT_LBD_WINDOW_US  250
`define BT_LOW_RUN        4

`endif

// *** shared/bt_pkg.sv ***
// types shared by the monitor modules
package bt_pkg;

   // sampler sequence states
   typedef enum logic [1:0] {
      SMP_IDLE    = 2'h0,
      SMP_MEASURE = 2'h1,
      SMP_WAIT    = 2'h2
   } sampler_state_e;

   typedef logic [6:0] reg_addr_t;   // spi register address
   typedef logic [7:0] reg_byte_t;   // register data byte

endpackage

// *** src/supply_sampler.sv ***
// periodic supply measurement and low-run counter of the detector
`timescale 1ns/1ps
`include "bt_cfg.svh"
module supply_sampler
   import bt_pkg::*;
#(
   parameter int PERIOD_CYC = 250000000,
   parameter int WINDOW_CYC = 62500
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic       enable,
   input  wire logic [4:0] threshold,
   input  wire logic [4:0] vbat_code,
   output logic            sensor_power,
   output logic [4:0]      level,
   output logic            low_event
);

   localparam int CW = $clog2(PERIOD_CYC + 1);

   // ------------
   // elaboration checks
   // ------------
   if (WINDOW_CYC < 1 || PERIOD_CYC <= WINDOW_CYC) begin : g_bad
      $error("sampler window must be shorter than its period");
   end

   sampler_state_e state_r, state_nxt;   // sequence state
   logic [CW-1:0]  cnt_r, cnt_nxt;       // cycles since the period began
   logic [2:0]     run_r, run_nxt;       // consecutive low samples
   logic [4:0]     level_r, level_nxt;   // last supply code
   logic           pow_r, pow_nxt;       // detector power
   logic           evt_r, evt_nxt;       // low run reached

   // ------------
   // next state
   // ------------
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      run_nxt   = run_r;
      level_nxt = level_r;
      pow_nxt   = 1'b0;
      evt_nxt   = 1'b0;
      case (state_r)
         // wait for enable, then measure at once
         SMP_IDLE: begin
            cnt_nxt = '0;
            run_nxt = 3'h0;
            if (enable) begin // R13
               state_nxt = SMP_MEASURE;
               pow_nxt   = 1'b1;
            end
         end
         // detector powered for the window
         SMP_MEASURE: begin
            cnt_nxt = cnt_r + 1'b1;
            pow_nxt = 1'b1; // R15
            if (cnt_r == CW'(WINDOW_CYC - 1)) begin
               pow_nxt   = 1'b0;
               state_nxt = SMP_WAIT;
               level_nxt = vbat_code; // R14
               if (vbat_code < threshold) begin // R17
                  if (run_r != 3'(`BT_LOW_RUN)) begin
                     run_nxt = run_r + 3'h1;
                  end
                  evt_nxt = (run_r >= 3'(`BT_LOW_RUN - 1));
               end else begin
                  run_nxt = 3'h0;
               end
            end
         end
         // idle rest of the second
         SMP_WAIT: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == CW'(PERIOD_CYC - 1)) begin // R15
               cnt_nxt   = '0;
               state_nxt = SMP_MEASURE;
               pow_nxt   = 1'b1;
            end
         end
         default: begin
            state_nxt = SMP_IDLE;
         end
      endcase
      // disable drops the sequence back to idle; the last level is kept
      if (!enable) begin // R13
         state_nxt = SMP_IDLE;
         pow_nxt   = 1'b0;
         evt_nxt   = 1'b0;
      end
   end

   // ------------
   // registers
   // ------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= SMP_IDLE;
         cnt_r   <= '0;
         run_r   <= 3'h0;
         level_r <= 5'h00;
         pow_r   <= 1'b0;
         evt_r   <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         run_r   <= run_nxt;
         level_r <= level_nxt;
         pow_r   <= pow_nxt;
         evt_r   <= evt_nxt;
      end
   end

   assign sensor_power = pow_r;
   assign level        = level_r;
   assign low_event    = evt_r;

endmodule

// *** testbench/battery_temp_monitor_chk.sv ***
// port checker of the battery and temperature monitor
`timescale 1ns/1ps
module battery_temp_monitor_chk #(
   parameter int CONV_CYC   = 20,
   parameter int WINDOW_CYC = 10
) (
   input wire logic       core_clk,
   input wire logic       srst,
   input wire logic       spi_cs_n,
   input wire logic       spi_miso_oe,
   input wire logic       interrupt_request_n,
   input wire logic       sleep_mode,
   input wire logic       atb_temp_sel,
   input wire logic       conv_power,
   input wire logic [2:0] conv_input_sel,
   input wire logic [1:0] conv_ref_sel,
   input wire logic [7:0] amp_gain_num,
   input wire logic [3:0] amp_offset_steps,
   input wire logic       temp_sensor_on,
   input wire logic       low_supply_detector_power,
   input wire logic       rc_osc_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   int conv_cnt_r; // cycles of the running conversion
   int win_cnt_r;  // cycles of the running window
   // length counters, cleared whenever the pulse is low
   always_ff @(posedge core_clk) begin
      conv_cnt_r <= (srst || !conv_power) ? 0 : conv_cnt_r + 1;
      win_cnt_r  <= (srst || !low_supply_detector_power) ? 0 : win_cnt_r + 1;
   end
   a_gain_half: assert property (!$past(conv_ref_sel[0]) |->
      amp_gain_num inside {8'h16, 8'h2c, 8'h42, 8'h58})
      else $error("gain off the half supply set");
   a_gain_third: assert property ($past(conv_ref_sel[0]) |->
      amp_gain_num inside {8'h21, 8'h42, 8'h63, 8'h84})
      else $error("gain off the third supply set");
   a_sensor_auto: assert property (!$past(srst) |->
      temp_sensor_on == ($past(conv_input_sel) == 3'h0 || $past(atb_temp_sel)))
      else $error("sensor power wrong");
   a_offset_code: assert property (amp_offset_steps != 4'h8)
      else $error("offset minus eight");
   a_rc_sleep: assert property (!$past(sleep_mode) |-> !rc_osc_on)
      else $error("oscillator on while awake");
   a_window_len: assert property (win_cnt_r <= WINDOW_CYC)
      else $error("window too long");
   a_irq_release: assert property (
      $rose(interrupt_request_n) |-> !spi_cs_n)
      else $error("interrupt released outside access");
   a_oe_idle: assert property (spi_cs_n [*8] |-> !spi_miso_oe)
      else $error("data out driven while idle");
   a_conv_len: assert property (conv_cnt_r <= CONV_CYC)
      else $error("conversion too long");
endmodule
bind battery_temp_monitor battery_temp_monitor_chk #(
   .CONV_CYC(CONV_CYC), .WINDOW_CYC(WINDOW_CYC)) u_chk (
   .core_clk, .srst, .spi_cs_n, .spi_miso_oe, .interrupt_request_n,
   .sleep_mode, .atb_temp_sel, .conv_power, .conv_input_sel, .conv_ref_sel,
   .amp_gain_num, .amp_offset_steps, .temp_sensor_on,
   .low_supply_detector_power, .rc_osc_on);

// *** testbench/spi_host.sv ***
// host controller model: register access master
`timescale 1ns/1ps
module spi_host (
   input  wire logic core_clk,
   output logic      spi_sck,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic miso_line
);
   // clock rests low, select high outside frames
   initial begin
      spi_sck  = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // wait n edges, then step just off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // one frame: rw bit, address, data; q holds the second byte seen
   task automatic xfer(input logic rw, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [15:0] sh;
      sh = {rw, a, d};
      q = 8'h00;
      spi_cs_n = 1'b0;
      tick(8);
      for (int i = 0; i < 16; i++) begin
         spi_mosi = sh[15 - i];
         tick(8);
         if (i > 7) q = {q[6:0], miso_line};
         spi_sck = 1'b1;
         tick(8);
         spi_sck = 1'b0;
      end
      tick(8);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // released line shows no stale level
      tick(8);
   endtask
endmodule

// *** testbench/battery_temp_monitor_tb.sv ***
// self-checking bench of the battery and temperature monitor
`timescale 1ns/1ps
module battery_temp_monitor_tb;
   logic       core_clk, srst, ce, sleep_mode, atb_temp_sel, miso_line;
   logic       spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic       interrupt_request_n, conv_power, temp_sensor_on, rc_osc_on;
   logic       thermal_shift_enable, low_supply_detector_power;
   logic [7:0] adc_result, amp_gain_num, temp_value_offset;
   logic [4:0] vbat_code;
   logic [2:0] conv_input_sel;
   logic [1:0] conv_ref_sel, temp_range;
   logic [3:0] amp_offset_steps, bandgap_trim;
   int         n_errors = 0;
   int         num_checks = 0;
   assign miso_line = spi_miso_oe ? spi_miso : 1'b1; // pulled up when idle
   battery_temp_monitor #(.CONV_CYC(400), .PERIOD_CYC(1000),
      .WINDOW_CYC(10)) u_dut (.core_clk, .srst, .ce, .spi_sck, .spi_cs_n,
      .spi_mosi, .spi_miso, .spi_miso_oe, .interrupt_request_n, .sleep_mode,
      .atb_temp_sel, .adc_result, .vbat_code, .conv_power, .conv_input_sel,
      .conv_ref_sel, .amp_gain_num, .amp_offset_steps, .temp_sensor_on,
      .temp_range, .thermal_shift_enable, .bandgap_trim, .temp_value_offset,
      .low_supply_detector_power, .rc_osc_on);
   spi_host u_host (.core_clk, .spi_sck, .spi_cs_n, .spi_mosi, .miso_line);
   // compare and count
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e, string nm);
      logic [7:0] q;
      u_host.xfer(1'b0, a, 8'h00, q);
      chk(nm, q, e);
   endtask
   task automatic close_out;
      if (n_errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // watchdog well beyond the expected 21k cycles
   initial begin
      #400000;
      n_errors++;
      close_out();
   end
   initial begin
      logic [7:0] e;
      {srst, ce, sleep_mode, atb_temp_sel} = 4'hc;
      adc_result = 8'h00;
      vbat_code = 5'h12;
      u_host.tick(4);
      srst = 1'b0;
      u_host.tick(4);
      chk("shift_en", {7'h0, thermal_shift_enable}, 8'h01);
      rd(7'h12, 8'h20, "ts_ctrl");
      rd(7'h1a, 8'h14, "thr");
      rd(7'h1b, 8'h00, "level_off");
      wr(7'h13, 8'ha5);
      wr(7'h1b, 8'h33);
      rd(7'h13, 8'ha5, "tvoffs");
      chk("tvoffs_pin", temp_value_offset, 8'ha5);
      ce = 1'b0;
      wr(7'h13, 8'h3c);
      ce = 1'b1;
      rd(7'h13, 8'ha5, "frozen");
      rd(7'h1b, 8'h00, "level_ro");
      rd(7'h7f, 8'h00, "unmapped");
      wr(7'h1a, 8'hff);
      rd(7'h1a, 8'h1f, "thr_mask");
      // every gain under both references, sensor input not chosen
      for (int i = 0; i < 8; i++) begin
         wr(7'h0f, {4'h1, 1'b0, i[2], i[1:0]});
         e = 8'((i[2] ? 8'h21 : 8'h16) * (i[1:0] + 1));
         chk("gain", amp_gain_num, e);
         chk("sensor_off", {7'h0, temp_sensor_on}, 8'h00);
      end
      for (int k = 0; k < 16; k++) begin
         wr(7'h10, 8'(k));
         e = k[3] ? {5'h0, k[2:0]} : {4'h0, k[2:0] != 3'h0, k[2:0]};
         chk("offs", {4'h0, amp_offset_steps}, e);
      end
      for (int r = 0; r < 4; r++) begin
         wr(7'h12, {r[1:0], 2'h3, 4'(r + 9)});
         chk("range", {6'h0, temp_range}, 8'(r));
         chk("trim", {4'h0, bandgap_trim}, 8'(r + 9));
      end
      wr(7'h12, 8'h47);
      e = {1'b0, temp_range, thermal_shift_enable, bandgap_trim};
      chk("abs", e, 8'h20);
      // temperature reading sequence with a conversion
      wr(7'h0f, 8'h00);
      wr(7'h12, 8'h20);
      chk("sensor_on", {7'h0, temp_sensor_on}, 8'h01);
      wr(7'h0f, 8'h80);
      adc_result = 8'h5a;
      chk("busy", {7'h0, conv_power}, 8'h01);
      rd(7'h0f, 8'h80, "busy_bit");
      u_host.tick(400);
      rd(7'h0f, 8'h00, "start_clear");
      rd(7'h11, 8'h5a, "adc");
      wr(7'h0f, 8'h10);
      atb_temp_sel = 1'b1;
      u_host.tick(3);
      chk("sensor_bus", {7'h0, temp_sensor_on}, 8'h01);
      atb_temp_sel = 1'b0;
      // detector in sleep, then four low samples
      wr(7'h06, 8'h04);
      wr(7'h1a, 8'h10);
      sleep_mode = 1'b1;
      wr(7'h07, 8'h40);
      chk("rc_on", {7'h0, rc_osc_on}, 8'h01);
      u_host.tick(1200);
      rd(7'h1b, 8'h12, "level");
      vbat_code = 5'h0f;
      repeat (3) @(negedge low_supply_detector_power);
      u_host.tick(4);
      chk("irq_wait", {7'h0, interrupt_request_n}, 8'h01);
      @(negedge low_supply_detector_power);
      u_host.tick(4);
      chk("irq_low", {7'h0, interrupt_request_n}, 8'h00);
      rd(7'h04, 8'h04, "flag");
      chk("irq_clr", {7'h0, interrupt_request_n}, 8'h01);
      rd(7'h03, 8'h00, "stat1");
      wr(7'h07, 8'h00);
      rd(7'h1b, 8'h00, "level_dis");
      close_out();
   end
endmodule
